/* File: inc/cptg_defs.vh */
// constants for the counter pulse train generator
`ifndef CPTG_DEFS_VH
`define CPTG_DEFS_VH
`define CPTG_CNT_W 16
`define CPTG_CNT_MAX 16'hffff
`define CPTG_CNT_ZERO 16'h0000
`define CPTG_CNT_ONE 16'h0001
`define CPTG_ST_IDLE 2'h0
`define CPTG_ST_ARM 2'h1
`define CPTG_ST_PH1 2'h2
`define CPTG_ST_PH2 2'h3
`define CPTG_GATE_OFF 2'h0
`define CPTG_GATE_EDGE 2'h1
`define CPTG_GATE_LEVEL 2'h2
`define CPTG_GATE_RETRIG 2'h3
`endif

/* File: hw/cptg_edge_det.v */
// source edge detector with selectable counted transition
`timescale 1ns/1ps
module cptg_edge_det (
  // clock and reset
  input wire clk,
  input wire srst,
  // sampled input and edge choice
  input wire sig,
  input wire falling,
  // one-cycle edge strobes
  output wire rise,
  output wire fall,
  output wire sel_edge
);
  reg prev_q;
  // previous sample, reset low
  always @(posedge clk) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sig;
    end
  end
  // edge strobes
  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;
  assign sel_edge = falling ? fall : rise;
endmodule

/* File: hw/cptg_top.v */
// counter pulse train generator: delayed pulse or continuous train
//
// Notes on behaviour
// - toggled mode inverts the output each time the count hits its terminal value.
// - pulsed mode emits a one-source-cycle pulse when the count hits its terminal value at the end of the delay phase.
// - polarity sets idle level; positive idles low, negative idles high, edges inverted.
// - delay phase runs from start to the first active output edge.
// - pulse phase runs from active edge to opposite edge, separately programmable.
// - continuous train repeats delay then pulse phase with no software help.
// - period equals delay length plus pulse length in source cycles.
// - frequency is the reciprocal of that period.
// - duty is pulse length over period; equal phases give one half.
// - duty of zero or one is replaced by nearest achievable, train still runs.
// - timing counts edges of internal timebase or external source, selectable.
// - optional gate qualifies generation; without gating, start alone runs it.
// - pulse count zero means continuous train, also the default.
// - configuration is held idle until a separate start command.
// - retriggerable mode restarts the sequence on a gate event during the pulse phase, a one-shot.
// - counted source edge is rising or falling, selectable.
// - counter counts up by default or down; terminal is max or zero.
`timescale 1ns/1ps
`include "cptg_defs.vh"
module cptg_top (
  // clock and reset
  input wire clk,
  input wire srst,
  // counter pins
  input wire timebase,
  input wire ext_source,
  input wire gate,
  output reg out,
  // configuration
  input wire src_ext,
  input wire src_falling,
  input wire count_down,
  input wire pulsed_mode,
  input wire neg_polarity,
  input wire [1:0] gate_mode,
  input wire gate_falling,
  input wire [15:0] delay_len,
  input wire [15:0] pulse_len,
  input wire [15:0] pulse_count,
  // commands
  input wire start,
  input wire stop,
  // status
  output wire running,
  output wire [15:0] count_value,
  output wire [15:0] terminal_count_value,
  output reg [15:0] pulses_done
);
  ////////////////////////////////////////////////////////////////////////
  // edge detection
  wire src_sig;
  wire src_edge;
  wire g_rise;
  wire g_fall;
  wire gate_evt;
  wire gate_lvl;
  assign src_sig = src_ext ? ext_source : timebase;
  cptg_edge_det u_src (
    .clk(clk),
    .srst(srst),
    .sig(src_sig),
    .falling(src_falling),
    .rise(),
    .fall(),
    .sel_edge(src_edge)
  );
  cptg_edge_det u_gate (
    .clk(clk),
    .srst(srst),
    .sig(gate),
    .falling(gate_falling),
    .rise(g_rise),
    .fall(g_fall),
    .sel_edge(gate_evt)
  );
  // level gate: active high, or active low when falling selected
  assign gate_lvl = gate_falling ? ~gate : gate;
  ////////////////////////////////////////////////////////////////////////
  // phase lengths, clamped so no phase is empty
  wire [15:0] ph1_len;
  wire [15:0] ph2_len;
  assign ph1_len = (delay_len == `CPTG_CNT_ZERO) ? `CPTG_CNT_ONE : delay_len;
  assign ph2_len = (pulse_len == `CPTG_CNT_ZERO) ? `CPTG_CNT_ONE : pulse_len;
  ////////////////////////////////////////////////////////////////////////
  // state and counter
  reg [1:0] state_q;
  reg [15:0] cnt_q;
  reg [15:0] load_q;
  reg active_q;
  reg pulse_q;
  wire [15:0] term;
  wire hit;
  wire count_en;
  wire [15:0] len_sel;
  wire [15:0] start_val;
  wire finite;
  assign term = count_down ? `CPTG_CNT_ZERO : `CPTG_CNT_MAX;
  assign terminal_count_value = term;
  assign count_value = cnt_q;
  assign running = (state_q != `CPTG_ST_IDLE);
  assign finite = (pulse_count != `CPTG_CNT_ZERO);
  // level gating pauses counting; other modes count every source edge
  assign count_en = src_edge & ((gate_mode != `CPTG_GATE_LEVEL) | gate_lvl);
  assign hit = count_en & (cnt_q == term);
  // preload so that terminal is reached after len edges: up from max-len+1
  function [15:0] preload;
    input [15:0] len;
    input down;
    begin
      if (down) begin
        preload = len - `CPTG_CNT_ONE;
      end else begin
        preload = `CPTG_CNT_MAX - len + `CPTG_CNT_ONE;
      end
    end
  endfunction
  assign len_sel = (state_q == `CPTG_ST_PH1) ? ph2_len : ph1_len;
  assign start_val = preload(ph1_len, count_down);
  wire trig;
  // retrigger restarts on a gate event only during the active pulse phase
  assign trig = (gate_mode == `CPTG_GATE_RETRIG) & gate_evt & active_q;
  // main sequencer; stop wins over everything but reset, config is read live in every state
  always @(posedge clk) begin
    if (srst) begin
      state_q <= `CPTG_ST_IDLE;
      cnt_q <= `CPTG_CNT_ZERO;
      load_q <= `CPTG_CNT_ZERO;
      active_q <= 1'b0;
      pulse_q <= 1'b0;
      pulses_done <= `CPTG_CNT_ZERO;
    end else if (stop) begin
      state_q <= `CPTG_ST_IDLE;
      active_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      case (state_q)
        `CPTG_ST_IDLE: begin
          if (start) begin
            // generation begins only on start; config is not latched here and is read live afterwards
            active_q <= 1'b0;
            pulses_done <= `CPTG_CNT_ZERO;
            cnt_q <= start_val;
            if (gate_mode == `CPTG_GATE_EDGE || gate_mode == `CPTG_GATE_RETRIG) begin
              state_q <= `CPTG_ST_ARM;
            end else begin
              state_q <= `CPTG_ST_PH1;
            end
          end
        end
        `CPTG_ST_ARM: begin
          if (gate_evt) begin
            state_q <= `CPTG_ST_PH1;
            cnt_q <= start_val;
          end
        end
        `CPTG_ST_PH1, `CPTG_ST_PH2: begin
          if (trig) begin
            state_q <= `CPTG_ST_PH1;
            cnt_q <= start_val;
            active_q <= 1'b0;
          end else if (hit) begin
            // terminal reached: end of a phase
            cnt_q <= preload(len_sel, count_down);
            if (pulsed_mode) begin
              pulse_q <= (state_q == `CPTG_ST_PH1);
            end
            if (state_q == `CPTG_ST_PH1) begin
              state_q <= `CPTG_ST_PH2;
              active_q <= 1'b1;
            end else begin
              active_q <= 1'b0;
              pulses_done <= pulses_done + `CPTG_CNT_ONE;
              if (finite && (pulses_done + `CPTG_CNT_ONE) >= pulse_count) begin
                // finite count done; retrigger mode re-arms as a one-shot
                state_q <= (gate_mode == `CPTG_GATE_RETRIG) ? `CPTG_ST_ARM : `CPTG_ST_IDLE;
              end else begin
                state_q <= `CPTG_ST_PH1;
              end
            end
          end else if (count_en) begin
            cnt_q <= count_down ? cnt_q - `CPTG_CNT_ONE : cnt_q + `CPTG_CNT_ONE;
          end
        end
        default: begin
          state_q <= `CPTG_ST_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // output stage: pulse lasts until the next counted source edge
  reg pstretch_q;
  always @(posedge clk) begin
    if (srst) begin
      pstretch_q <= 1'b0;
    end else if (pulse_q) begin
      pstretch_q <= 1'b1;
    end else if (src_edge | stop) begin
      pstretch_q <= 1'b0;
    end
  end
  // registered pin, idle level follows polarity
  always @(posedge clk) begin
    if (srst) begin
      out <= 1'b0;
    end else if (pulsed_mode) begin
      out <= neg_polarity ^ (pstretch_q | pulse_q);
    end else begin
      out <= neg_polarity ^ active_q;
    end
  end
endmodule

/* File: tb/cptg_assertions.sv */
// port checker of the counter pulse train generator
`timescale 1ns/1ps
module cptg_assertions (
  // clock and reset
  input logic clk,
  input logic srst,
  // commands and status
  input logic start,
  input logic stop,
  input logic running,
  input logic out,
  // configuration and counter status
  input logic neg_polarity,
  input logic count_down,
  input logic [15:0] pulse_count,
  input logic [15:0] pulses_done,
  input logic [15:0] terminal_count_value,
  input logic [1:0] gate_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // idle level only after a settled polarity, output is registered one cycle late
  chk_idle_level: assert property ((!running && $stable(neg_polarity))[*3] |-> out == neg_polarity)
    else $error("output not at idle level while stopped");
  chk_term_up: assert property (!count_down |-> terminal_count_value == 16'hffff)
    else $error("terminal value wrong when counting up");
  chk_term_down: assert property (count_down |-> terminal_count_value == 16'h0000)
    else $error("terminal value wrong when counting down");
  chk_start_runs: assert property (start && !running && !stop |=> running)
    else $error("start did not begin generation");
  chk_stop_halts: assert property (stop |=> !running)
    else $error("stop did not end generation");
  chk_no_self_start: assert property (!running && !start |=> !running)
    else $error("generation began without start");
  chk_done_frozen: assert property (!running && !start |=> $stable(pulses_done))
    else $error("period count moved while stopped");
  // a finite train must end soon after its last period; retrigger mode re-arms instead
  chk_finite_end: assert property ($changed(pulses_done) && pulses_done == pulse_count
    && pulse_count != 16'h0000 && gate_mode != 2'h3 |-> ##[0:8] !running)
    else $error("finite train kept running");
  cover property ($rose(running));
  cover property ($rose(out));
  cover property ($fell(running) && pulse_count != 16'h0000);
  cover property (running && gate_mode == 2'h3 && $changed(pulses_done));
endmodule
bind cptg_top cptg_assertions chk_i (.clk(clk), .srst(srst), .start(start), .stop(stop),
  .running(running), .out(out), .neg_polarity(neg_polarity), .count_down(count_down),
  .pulse_count(pulse_count), .pulses_done(pulses_done),
  .terminal_count_value(terminal_count_value), .gate_mode(gate_mode));

/* File: tb/cptg_sink.sv */
// receiving device: measures active and idle spans of the output line
`timescale 1ns/1ps
module cptg_sink (
  // clock
  input logic clk,
  // observed line and its idle level
  input logic level,
  input logic neg,
  // last completed spans in clock cycles
  output int act_len,
  output int idle_len
);
  int run = 0;
  logic last = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // a span closes on each change; active means away from the idle level
  always @(posedge clk) begin
    if (level !== last) begin
      if (last ^ neg) act_len <= run;
      else idle_len <= run;
      run <= 1;
    end else run <= run + 1;
    last <= level;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the counter pulse train generator
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end
module testbench;
  logic clk = 0, srst = 1, timebase = 0, ext_source = 0, gate = 0, out, running;
  logic src_ext = 0, src_falling = 0, count_down = 0, pulsed_mode = 0, neg_polarity = 0;
  logic gate_falling = 0, start = 0, stop = 0;
  logic [1:0] gate_mode = 2'h0;
  logic [15:0] delay_len = 16'h0001, pulse_len = 16'h0001, pulse_count = 16'h0000;
  logic [15:0] count_value, terminal_count_value, pulses_done;
  int err_total = 0, compares = 0, cycles = 0, act_len, idle_len;
  cptg_top dut (.clk(clk), .srst(srst), .timebase(timebase), .ext_source(ext_source),
    .gate(gate), .out(out), .src_ext(src_ext), .src_falling(src_falling),
    .count_down(count_down), .pulsed_mode(pulsed_mode), .neg_polarity(neg_polarity),
    .gate_mode(gate_mode), .gate_falling(gate_falling), .delay_len(delay_len),
    .pulse_len(pulse_len), .pulse_count(pulse_count), .start(start), .stop(stop),
    .running(running), .count_value(count_value),
    .terminal_count_value(terminal_count_value), .pulses_done(pulses_done));
  cptg_sink sink (.clk(clk), .level(out), .neg(neg_polarity), .act_len(act_len),
    .idle_len(idle_len));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  // sources of period 4 and 6 clocks; the cycle ceiling cuts a hang short
  always @(negedge clk) begin
    cycles++;
    if (cycles % 2 == 0) timebase <= ~timebase;
    if (cycles % 3 == 0) ext_source <= ~ext_source;
    if (cycles > 20000) begin
      err_total++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic go;
    start = 1;
    @(negedge clk);
    start = 0;
  endtask
  task automatic halt;
    stop = 1;
    @(negedge clk);
    stop = 0;
    repeat (3) @(negedge clk);
    `CHK(out, neg_polarity)
  endtask
  // steady-state spans of a continuous train, measured at the receiver
  task automatic t_train(input logic ext, fall, pls, neg, dn, input int dl, pl);
    int p, d;
    p = ext ? 6 : 4;
    d = (dl < 1) ? 1 : dl;
    {src_ext, src_falling, pulsed_mode, neg_polarity, count_down} = {ext, fall, pls, neg, dn};
    delay_len = dl[15:0];
    pulse_len = pl[15:0];
    repeat (4) @(negedge clk);
    `CHK(out, neg)
    `CHK(terminal_count_value, dn ? 16'h0000 : 16'hffff)
    go;
    repeat (4 * (d + pl) * p + 8) @(negedge clk);
    `CHK(act_len, pls ? p : pl * p)
    `CHK(idle_len, pls ? (d + pl - 1) * p : d * p)
    halt;
  endtask
  task automatic t_finite;
    pulse_count = 16'h0002;
    go;
    repeat (100) @(negedge clk);
    `CHK(pulses_done, 16'h0002)
    `CHK(running, 1'b0)
    pulse_count = 16'h0000;
  endtask
  // edge-gated one pulse: nothing leaves before the gate edge
  task automatic t_gate;
    gate_mode = 2'h1;
    pulse_count = 16'h0001;
    go;
    repeat (40) @(negedge clk);
    `CHK(out, 1'b0)
    `CHK(running, 1'b1)
    gate = 1;
    repeat (60) @(negedge clk);
    `CHK(pulses_done, 16'h0001)
    gate = 0;
    gate_mode = 2'h0;
    pulse_count = 16'h0000;
    halt;
  endtask
  // level gating, active low: counting pauses while the gate is inactive
  task automatic t_level;
    logic [15:0] v;
    gate_mode = 2'h2;
    gate_falling = 1;
    gate = 1;
    delay_len = 16'h0003;
    pulse_len = 16'h0001;
    go;
    repeat (4) @(negedge clk);
    v = count_value;
    repeat (20) @(negedge clk);
    `CHK(out, 1'b0)
    `CHK(count_value, v)
    gate = 0;
    repeat (72) @(negedge clk);
    `CHK(act_len, 4)
    `CHK(idle_len, 12)
    halt;
    gate_mode = 2'h0;
    gate_falling = 0;
  endtask
  // retriggered one-shot: each gate edge gives one period, then re-arms
  task automatic t_retrig;
    gate_mode = 2'h3;
    pulse_count = 16'h0001;
    go;
    repeat (20) @(negedge clk);
    `CHK(out, 1'b0)
    repeat (2) begin
      gate = 1;
      repeat (2) @(negedge clk);
      gate = 0;
      repeat (40) @(negedge clk);
    end
    `CHK(pulses_done, 16'h0002)
    `CHK(running, 1'b1)
    halt;
    gate_mode = 2'h0;
    pulse_count = 16'h0000;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    @(negedge clk);
    t_train(0, 0, 0, 0, 0, 3, 2);
    t_train(0, 0, 0, 1, 0, 2, 2);
    t_train(1, 1, 0, 0, 1, 2, 3);
    t_train(0, 0, 1, 0, 0, 3, 1);
    t_train(0, 0, 0, 0, 0, 0, 2);
    t_finite;
    t_gate;
    t_level;
    t_retrig;
    give_verdict;
  end
endmodule
